/* File: verilog/dec_top.sv */
// Behaviour
// - DMA traffic ignores other channels' ordering
// - No PCI starts during address-only lock
// - No PCI starts inside foreign read-modify-write
// - No VME transfers while ownership hold set
// - Active while running; one flag at end
// - Done on normal end; stop/halt on user
// - Each termination interrupts only if enabled
// - PCI aborts set PCI error, cause recorded
// - VME error only from BERR in cycle
// - Go with bad setup sets protocol error
// - Control kept; count tracks source bytes
// - Source error drains queue, then flags
// - Destination error halts both sides at once
// - Separate PCI and VME error enables
// - One merged request, routed PCI/VME/both
// - No destination-side byte count kept
// - Enabled interrupt sets both status bits
`timescale 1ns/1ns
module dec_top #(
  parameter int COUNT_W = dec_pkg::COUNT_W
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [dec_pkg::ADDR_W-1:0] regAddr,
  input wire logic [dec_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [dec_pkg::DATA_W-1:0] regRdData,
  input wire logic busMasterEnable,
  input wire logic addressOnlyLockCycle,
  input wire logic rmwInFlight,
  input wire logic vmeOwnershipHold,
  input wire logic vmeBerrN,
  input wire logic vmeCycleActive,
  input wire logic pciMasterAbort,
  input wire logic pciTargetAbort,
  input wire logic srcBeat,
  input wire logic [dec_pkg::BEAT_W-1:0] srcBeatBytes,
  input wire logic queueEmpty,
  input wire logic packetDone,
  input wire logic runComplete,
  output logic dmaActive,
  output logic srcReadEn,
  output logic dstWriteEn,
  output logic pciMayStart,
  output logic vmeMayStart,
  output logic [dec_pkg::DATA_W-1:0] transferControl,
  output logic [COUNT_W-1:0] transferByteCount,
  output logic pciIrqOut,
  output logic vmeIrqOut
);

  function automatic logic hit(input logic [dec_pkg::ADDR_W-1:0] a, input logic [dec_pkg::ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  dec_pkg::dec_state_e state_q;
  dec_pkg::dec_state_e stateD;
  logic [dec_pkg::NUM_TERM-1:0] status_q;
  logic [dec_pkg::NUM_TERM-1:0] en_q;
  logic [dec_pkg::DATA_W-1:0] xferCtl_q;
  logic [COUNT_W-1:0] count_q;
  logic [dec_pkg::DATA_W-1:0] pciAddr_q;
  logic [dec_pkg::DATA_W-1:0] vmeAddr_q;
  logic [1:0] route_q;
  logic [1:0] irqStat_q;
  logic [1:0] cause_q;
  logic haltPend_q;
  logic drainPci_q;
  logic berrSync;

  dec_sync #(.WIDTH(1), .RESET_VAL(1'b1)) uBerrSync (
    .mclk(mclk),
    .resetn(resetn),
    .asyncIn(vmeBerrN),
    .syncOut(berrSync)
  );

  // Write decode
  wire wrGcs = regWr && hit(regAddr, dec_pkg::OFF_GCS);
  wire wrXctl = regWr && hit(regAddr, dec_pkg::OFF_XCTL);
  wire wrCount = regWr && hit(regAddr, dec_pkg::OFF_COUNT);
  wire wrPciAddr = regWr && hit(regAddr, dec_pkg::OFF_PCIADDR);
  wire wrVmeAddr = regWr && hit(regAddr, dec_pkg::OFF_VMEADDR);
  wire wrRoute = regWr && hit(regAddr, dec_pkg::OFF_ROUTE);
  wire wrIrqStat = regWr && hit(regAddr, dec_pkg::OFF_IRQSTAT);
  wire wrCause = regWr && hit(regAddr, dec_pkg::OFF_CAUSE);

  wire idle = (state_q == dec_pkg::ST_IDLE);
  wire running = !idle;
  wire goWr = wrGcs && regWrData[dec_pkg::GCS_GO] && idle;
  wire stopWr = wrGcs && regWrData[dec_pkg::GCS_STOP];
  wire haltWr = wrGcs && regWrData[dec_pkg::GCS_HALT];

  // Setup checks at go
  wire misaligned = pciAddr_q[dec_pkg::ALIGN_W-1:0] != vmeAddr_q[dec_pkg::ALIGN_W-1:0];
  wire protErr = goWr && (!busMasterEnable || misaligned);
  wire startRun = goWr && !protErr;

  // Bus error detection while running; VME errors only in cycles flagged by vmeCycleActive
  wire pciErrEv = running && (pciMasterAbort || pciTargetAbort);
  wire vmeErrEv = running && vmeCycleActive && !berrSync;
  wire srcIsPci = xferCtl_q[dec_pkg::XCTL_DIR];
  wire srcErr = srcIsPci ? pciErrEv : vmeErrEv;
  wire dstErr = srcIsPci ? vmeErrEv : pciErrEv;

  // Termination causes, prioritised so that only one fires
  wire dstTerm = running && dstErr;
  wire drainTerm = (state_q == dec_pkg::ST_DRAIN) && queueEmpty && !dstErr;
  wire inRun = (state_q == dec_pkg::ST_RUN) && !dstErr && !srcErr;
  wire stopTerm = inRun && stopWr;
  wire haltTerm = inRun && !stopWr && haltPend_q && packetDone;
  wire doneTerm = inRun && !stopWr && !haltTerm && runComplete;

  wire [dec_pkg::NUM_TERM-1:0] termVec;
  assign termVec[dec_pkg::T_STOP] = stopTerm;
  assign termVec[dec_pkg::T_HALT] = haltTerm;
  assign termVec[dec_pkg::T_DONE] = doneTerm;
  assign termVec[dec_pkg::T_PCI] = (dstTerm && !srcIsPci) || (drainTerm && drainPci_q);
  assign termVec[dec_pkg::T_VME] = (dstTerm && srcIsPci) || (drainTerm && !drainPci_q);
  assign termVec[dec_pkg::T_PROT] = protErr;
  wire anyTerm = |termVec;

  // Next state
  assign stateD = anyTerm ? dec_pkg::ST_IDLE :
                  startRun ? dec_pkg::ST_RUN :
                  ((state_q == dec_pkg::ST_RUN) && srcErr) ? dec_pkg::ST_DRAIN : state_q;

  // Status: hardware set wins over software clear; go wipes old status
  wire [dec_pkg::NUM_TERM-1:0] statClr = wrGcs ? regWrData[dec_pkg::STAT_LSB +: dec_pkg::NUM_TERM] : '0;
  wire [dec_pkg::NUM_TERM-1:0] goClr = goWr ? '1 : '0;
  wire [dec_pkg::NUM_TERM-1:0] status_d = (status_q & ~statClr & ~goClr) | termVec;

  // Interrupt merge; error enables are separate bits of en_q
  // Enables in force at this edge, so a go or stop word's own enables apply at once
  wire [dec_pkg::NUM_TERM-1:0] en_d = wrGcs ? regWrData[dec_pkg::EN_LSB +: dec_pkg::NUM_TERM] : en_q;
  wire irqEvent = |(termVec & en_d);
  wire dmaIrq = |(status_q & en_q);
  wire [1:0] irqClr = wrIrqStat ? regWrData[1:0] : 2'b00;
  wire [1:0] irqStat_d = (irqStat_q & ~irqClr) | {2{irqEvent}};

  wire [1:0] causeSet = {pciTargetAbort && running, pciMasterAbort && running};
  wire [1:0] causeClr = wrCause ? regWrData[1:0] : 2'b00;
  wire [1:0] cause_d = (cause_q & ~causeClr) | causeSet;

  // Count holds remaining source bytes only
  wire [COUNT_W-1:0] beatExt = {{(COUNT_W-dec_pkg::BEAT_W){1'b0}}, srcBeatBytes};
  wire countDec = (state_q == dec_pkg::ST_RUN) && srcBeat;
  wire [COUNT_W-1:0] count_d = (wrCount && idle) ? regWrData[COUNT_W-1:0] :
                               countDec ? (count_q - beatExt) : count_q;

  wire haltPend_d = idle ? 1'b0 : (haltWr ? 1'b1 : haltPend_q);

  // Datapath permissions, no dependence on other channel traffic
  wire activeD = (stateD != dec_pkg::ST_IDLE);
  wire srcReadEn_d = (stateD == dec_pkg::ST_RUN);
  wire pciMayStart_d = activeD && !addressOnlyLockCycle && !rmwInFlight;
  wire vmeMayStart_d = activeD && !vmeOwnershipHold;

  // Read path
  wire [dec_pkg::DATA_W-1:0] gcsRead = (dec_pkg::DATA_W'(en_q) << dec_pkg::EN_LSB) |
                                       (dec_pkg::DATA_W'(status_q) << dec_pkg::STAT_LSB) |
                                       (dec_pkg::DATA_W'(running) << dec_pkg::GCS_ACT) |
                                       (dec_pkg::DATA_W'(haltPend_q) << dec_pkg::GCS_HALT);
  wire [dec_pkg::DATA_W-1:0] rdMux =
    hit(regAddr, dec_pkg::OFF_GCS) ? gcsRead :
    hit(regAddr, dec_pkg::OFF_XCTL) ? xferCtl_q :
    hit(regAddr, dec_pkg::OFF_COUNT) ? dec_pkg::DATA_W'(count_q) :
    hit(regAddr, dec_pkg::OFF_PCIADDR) ? pciAddr_q :
    hit(regAddr, dec_pkg::OFF_VMEADDR) ? vmeAddr_q :
    hit(regAddr, dec_pkg::OFF_ROUTE) ? dec_pkg::DATA_W'(route_q) :
    hit(regAddr, dec_pkg::OFF_IRQSTAT) ? dec_pkg::DATA_W'(irqStat_q) :
    hit(regAddr, dec_pkg::OFF_CAUSE) ? dec_pkg::DATA_W'(cause_q) : dec_pkg::RESET_WORD;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= dec_pkg::ST_IDLE;
      status_q <= '0;
      irqStat_q <= 2'b00;
      cause_q <= 2'b00;
      count_q <= dec_pkg::RESET_COUNT;
      haltPend_q <= 1'b0;
      drainPci_q <= 1'b0;
    end
    else
    begin
      state_q <= stateD;
      status_q <= status_d;
      irqStat_q <= irqStat_d;
      cause_q <= cause_d;
      count_q <= count_d;
      haltPend_q <= haltPend_d;
      if ((state_q == dec_pkg::ST_RUN) && srcErr)
      begin
        drainPci_q <= srcIsPci;
      end
    end
  end

  // Software setup registers; control and addresses frozen while a run is in progress, enables and route always writable
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      en_q <= '0;
      xferCtl_q <= dec_pkg::RESET_WORD;
      pciAddr_q <= dec_pkg::RESET_WORD;
      vmeAddr_q <= dec_pkg::RESET_WORD;
      route_q <= 2'b00;
    end
    else
    begin
      if (wrGcs)
      begin
        en_q <= en_d;
      end
      if (wrXctl && idle)
      begin
        xferCtl_q <= regWrData;
      end
      if (wrPciAddr && idle)
      begin
        pciAddr_q <= regWrData;
      end
      if (wrVmeAddr && idle)
      begin
        vmeAddr_q <= regWrData;
      end
      if (wrRoute)
      begin
        route_q <= regWrData[1:0];
      end
    end
  end

  // Registered outputs
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      regRdData <= dec_pkg::RESET_WORD;
      dmaActive <= 1'b0;
      srcReadEn <= 1'b0;
      dstWriteEn <= 1'b0;
      pciMayStart <= 1'b0;
      vmeMayStart <= 1'b0;
      pciIrqOut <= 1'b0;
      vmeIrqOut <= 1'b0;
    end
    else
    begin
      regRdData <= regRd ? rdMux : dec_pkg::RESET_WORD;
      dmaActive <= activeD;
      srcReadEn <= srcReadEn_d;
      dstWriteEn <= activeD;
      pciMayStart <= pciMayStart_d;
      vmeMayStart <= vmeMayStart_d;
      pciIrqOut <= dmaIrq && route_q[dec_pkg::ROUTE_PCI];
      vmeIrqOut <= dmaIrq && route_q[dec_pkg::ROUTE_VME];
    end
  end

  assign transferControl = xferCtl_q;
  assign transferByteCount = count_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence srcFault;
    (state_q == dec_pkg::ST_RUN) && srcErr && !dstErr && !stopWr;
  endsequence

  sequence drainHeld;
    !srcReadEn && dstWriteEn && (state_q == dec_pkg::ST_DRAIN);
  endsequence

  AST_ONE_FLAG: assert property (anyTerm |-> $onehot(termVec)) else $error("more than one termination");
  AST_ACT_DROP: assert property (anyTerm |=> !dmaActive && idle) else $error("active after termination");
  AST_DONE_SET: assert property (doneTerm |=> status_q[dec_pkg::T_DONE] && !dmaActive) else $error("done missing");
  AST_IRQ_GATE: assert property (pciIrqOut |-> $past(dmaIrq)) else $error("interrupt without enabled status");
  AST_PROT_GO: assert property (goWr && !busMasterEnable |=> status_q[dec_pkg::T_PROT] && !dmaActive)
    else $error("protocol error missed");
  AST_LOCK_PCI: assert property (addressOnlyLockCycle |=> !pciMayStart) else $error("PCI start during lock");
  AST_RMW_PCI: assert property (rmwInFlight |=> !pciMayStart) else $error("PCI start during rmw");
  AST_VME_OWNERSHIP_HOLD_VME: assert property (vmeOwnershipHold |=> !vmeMayStart) else $error("VME start during hold");
  AST_SRC_DRAIN: assert property (srcFault |=> drainHeld) else $error("source error did not drain");
  AST_DST_STOP: assert property (dstTerm |=> !srcReadEn && !dstWriteEn) else $error("destination error kept going");
  AST_BOTH_STAT: assert property (irqEvent |=> irqStat_q == 2'b11) else $error("interrupt status not set");
  AST_VME_CAUSE: assert property ($rose(status_q[dec_pkg::T_VME]) |-> $past(dstTerm || drainTerm))
    else $error("VME flag without error path");
  AST_COUNT_DEC: assert property (countDec && !wrCount |=> count_q == $past(count_q) - $past(beatExt))
    else $error("byte count not decremented");
  AST_GO_CLEAR: assert property (startRun |=> status_q == '0) else $error("old status survived go");

endmodule // dec_top

/* File: shared/dec_pkg.sv */
package dec_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int COUNT_W = 24;
  localparam int BEAT_W = 4;
  localparam int ALIGN_W = 3;
  localparam int NUM_TERM = 6;
  localparam int QUEUE_BYTES = 256;

  // Register offsets, byte addresses
  localparam logic [ADDR_W-1:0] OFF_GCS = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_XCTL = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PCIADDR = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_VMEADDR = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_ROUTE = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_IRQSTAT = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_CAUSE = 8'h1c;

  // General control and status fields
  localparam int GCS_GO = 0;
  localparam int GCS_STOP = 1;
  localparam int GCS_HALT = 2;
  localparam int GCS_ACT = 7;
  localparam int STAT_LSB = 8;
  localparam int EN_LSB = 16;

  // Termination index within status and enable fields
  localparam int T_STOP = 0;
  localparam int T_HALT = 1;
  localparam int T_DONE = 2;
  localparam int T_PCI = 3;
  localparam int T_VME = 4;
  localparam int T_PROT = 5;

  // Transfer control: direction bit, 1 = PCI source, VME destination
  localparam int XCTL_DIR = 31;

  localparam int ROUTE_PCI = 0;
  localparam int ROUTE_VME = 1;
  localparam int IRQ_PCI = 0;
  localparam int IRQ_VME = 1;
  localparam int CAUSE_MASTER = 0;
  localparam int CAUSE_TARGET = 1;

  localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
  localparam logic [COUNT_W-1:0] RESET_COUNT = 24'h00_0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DRAIN = 2'b10
  } dec_state_e;

endpackage

/* File: verilog/dec_sync.sv */
`timescale 1ns/1ns
module dec_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      stage1_q <= RESET_VAL;
      syncOut <= RESET_VAL;
    end
    else
    begin
      stage1_q <= asyncIn;
      syncOut <= stage1_q;
    end
  end

endmodule // dec_sync

/* File: verification/dec_far_model.sv */
`timescale 1ns/1ns
module dec_far_model (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic srcReadEn,
  input wire logic dstWriteEn,
  input wire logic vmeMayStart,
  input wire logic stall,
  input wire logic injMaster,
  input wire logic injTarget,
  input wire logic injBerr,
  input wire logic [31:0] rnd,
  output logic srcBeat,
  output logic [dec_pkg::BEAT_W-1:0] srcBeatBytes,
  output logic queueEmpty,
  output logic pciMasterAbort,
  output logic pciTargetAbort,
  output logic vmeBerrN,
  output logic vmeCycleActive,
  output logic [23:0] bytesSent
);
  logic [8:0] levelQ;
  logic [8:0] drain;
  // Beats only while reads are allowed and the queue has room
  assign srcBeat = srcReadEn & rnd[0] & (levelQ < 9'h0f8);
  assign srcBeatBytes = {1'b0, rnd[3:1]} + 4'h1;
  assign drain = (dstWriteEn & ~stall) ? ((levelQ > 9'h008) ? 9'h008 : levelQ) : 9'h000;
  assign queueEmpty = (levelQ == 9'h000);
  assign pciMasterAbort = injMaster;
  assign pciTargetAbort = injTarget;
  // Pulled-up line, low only when commanded
  assign vmeBerrN = ~injBerr;
  assign vmeCycleActive = vmeMayStart & (srcReadEn | dstWriteEn);
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      levelQ <= 9'h000;
      bytesSent <= 24'h000000;
    end
    else
    begin
      // Queue flushed once the engine lets go of both sides
      levelQ <= (srcReadEn | dstWriteEn) ? levelQ + (srcBeat ? {5'h00, srcBeatBytes} : 9'h000) - drain : 9'h000;
      bytesSent <= bytesSent + (srcBeat ? {20'h00000, srcBeatBytes} : 24'h000000);
    end
  end
endmodule // dec_far_model

/* File: verification/test_dma_error_termination_control.sv */
`timescale 1ns/1ns
module test_dma_error_termination_control;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic bm = 1'b1;
  logic [2:0] gates = 3'h0;
  logic stall = 1'b0;
  logic injM = 1'b0;
  logic injT = 1'b0;
  logic injB = 1'b0;
  logic packetDone = 1'b0;
  logic runComplete = 1'b0;
  logic [31:0] rnd = 32'hc8715a5e;
  logic [31:0] regRdData;
  logic [31:0] xctl;
  logic [23:0] count;
  logic [23:0] sent;
  logic [3:0] beatBytes;
  logic srcBeat, queueEmpty, mAbort, tAbort, berrN, vmeCyc, dmaActive, srcReadEn, dstWriteEn;
  logic pciMayStart, vmeMayStart, pciIrqOut, vmeIrqOut;
  int miscompares = 0;
  int n_checks = 0;
  dec_top dec_top_inst (.mclk(mclk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .busMasterEnable(bm), .addressOnlyLockCycle(gates[0]),
    .rmwInFlight(gates[1]), .vmeOwnershipHold(gates[2]), .vmeBerrN(berrN), .vmeCycleActive(vmeCyc),
    .pciMasterAbort(mAbort), .pciTargetAbort(tAbort), .srcBeat(srcBeat), .srcBeatBytes(beatBytes),
    .queueEmpty(queueEmpty), .packetDone(packetDone), .runComplete(runComplete), .dmaActive(dmaActive),
    .srcReadEn(srcReadEn), .dstWriteEn(dstWriteEn), .pciMayStart(pciMayStart), .vmeMayStart(vmeMayStart),
    .transferControl(xctl), .transferByteCount(count), .pciIrqOut(pciIrqOut), .vmeIrqOut(vmeIrqOut));
  dec_far_model dec_far_model_inst (.mclk(mclk), .resetn(resetn), .srcReadEn(srcReadEn), .dstWriteEn(dstWriteEn),
    .vmeMayStart(vmeMayStart), .stall(stall), .injMaster(injM), .injTarget(injT), .injBerr(injB), .rnd(rnd),
    .srcBeat(srcBeat), .srcBeatBytes(beatBytes), .queueEmpty(queueEmpty), .pciMasterAbort(mAbort),
    .pciTargetAbort(tAbort), .vmeBerrN(berrN), .vmeCycleActive(vmeCyc), .bytesSent(sent));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [31:0] gcsExp(input int k, input logic [5:0] en);
    return {10'h000, en, 2'b00, 6'h01 << k, 8'h00};
  endfunction
  task automatic close_out();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    chk(regRdData & m, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic run(input int k, input logic [5:0] en, input logic [1:0] rt, input logic dir);
    logic [23:0] cnt;
    logic [23:0] base;
    logic [31:0] xc;
    logic [31:0] pa;
    logic [31:0] va;
    logic [23:0] resumeCnt;
    logic irq;
    logic mis;
    int i;
    cnt = {4'h1, rnd[19:0]};
    xc = {dir, rnd[30:0]};
    irq = |((6'h01 << k) & en);
    mis = rnd[7];
    // Own copies of the start addresses for recovery
    pa = {rnd[31:3], 3'h5};
    va = {rnd[28:0], (k == dec_pkg::T_PROT && mis) ? 3'h4 : 3'h5};
    @(posedge mclk);
    stall <= (k == dec_pkg::T_PCI || k == dec_pkg::T_VME);
    bm <= ~(k == dec_pkg::T_PROT && ~mis);
    wr(dec_pkg::OFF_ROUTE, {30'h0, rt});
    wr(dec_pkg::OFF_XCTL, xc);
    wr(dec_pkg::OFF_COUNT, {8'h00, cnt});
    wr(dec_pkg::OFF_PCIADDR, pa);
    wr(dec_pkg::OFF_VMEADDR, va);
    wr(dec_pkg::OFF_IRQSTAT, 32'h3);
    wr(dec_pkg::OFF_CAUSE, 32'h3);
    base = sent;
    wr(dec_pkg::OFF_GCS, {10'h000, en, 16'h0001});
    #1;
    if (k != dec_pkg::T_PROT)
      rd(dec_pkg::OFF_GCS, 32'h00003f80, 32'h00000080);
    case (k)
      dec_pkg::T_STOP: wr(dec_pkg::OFF_GCS, {10'h000, en, 16'h0002});
      dec_pkg::T_HALT:
      begin
        wr(dec_pkg::OFF_GCS, {10'h000, en, 16'h0004});
        rd(dec_pkg::OFF_GCS, 32'h00000084, 32'h00000084);
        @(posedge mclk);
        packetDone <= 1'b1;
        @(posedge mclk);
        packetDone <= 1'b0;
      end
      dec_pkg::T_DONE:
      begin
        // Refused while running, so the count must survive
        wr(dec_pkg::OFF_COUNT, 32'h0);
        for (i = 0; i < 3; i++)
        begin
          @(posedge mclk);
          gates <= 3'h1 << i;
          tick(3);
          chk({30'h0, pciMayStart, vmeMayStart}, (i == 2) ? 32'h2 : 32'h1);
          @(posedge mclk);
          gates <= 3'h0;
          tick(3);
          chk({30'h0, pciMayStart, vmeMayStart}, 32'h3);
        end
        @(posedge mclk);
        runComplete <= 1'b1;
        @(posedge mclk);
        runComplete <= 1'b0;
      end
      default:
      if (k != dec_pkg::T_PROT)
      begin
        // Queue must hold data so that a source error has something to drain
        for (i = 0; i < 50 && queueEmpty !== 1'b0; i++)
          tick(1);
        if (i == 50)
        begin
          miscompares++;
          close_out();
        end
        @(posedge mclk);
        injM <= (k == dec_pkg::T_PCI) & mis;
        injT <= (k == dec_pkg::T_PCI) & ~mis;
        injB <= (k == dec_pkg::T_VME);
        @(posedge mclk);
        injM <= 1'b0;
        injT <= 1'b0;
        tick(3);
        // Source error drains with the queue stalled; destination error stops at once
        chk({29'h0, dmaActive, srcReadEn, dstWriteEn}, (dir == (k == dec_pkg::T_PCI)) ? 32'h5 : 32'h0);
        @(posedge mclk);
        injB <= 1'b0;
        stall <= 1'b0;
      end
    endcase
    #1;
    for (i = 0; i < 300 && dmaActive !== 1'b0; i++)
      tick(1);
    if (i == 300)
    begin
      miscompares++;
      close_out();
    end
    tick(2);
    chk({30'h0, pciIrqOut, vmeIrqOut}, {30'h0, irq & rt[0], irq & rt[1]});
    rd(dec_pkg::OFF_GCS, 32'h003fff80, gcsExp(k, en));
    rd(dec_pkg::OFF_IRQSTAT, 32'h3, {30'h0, irq, irq});
    wr(dec_pkg::OFF_IRQSTAT, 32'h1);
    rd(dec_pkg::OFF_IRQSTAT, 32'h3, {30'h0, irq, 1'b0});
    if (k == dec_pkg::T_PCI)
      rd(dec_pkg::OFF_CAUSE, 32'h3, mis ? 32'h1 : 32'h2);
    chk(xctl, xc);
    chk({8'h00, count}, {8'h00, cnt - (sent - base)});
    if (k == dec_pkg::T_PCI || k == dec_pkg::T_VME)
    begin
      // Resume from our own copies, one queue depth back if far enough in
      resumeCnt = ((cnt - count) < 24'h000100) ? cnt : count + 24'h000100;
      wr(dec_pkg::OFF_COUNT, {8'h00, resumeCnt});
      wr(dec_pkg::OFF_PCIADDR, pa + {8'h00, cnt - resumeCnt});
      wr(dec_pkg::OFF_VMEADDR, va + {8'h00, cnt - resumeCnt});
      wr(dec_pkg::OFF_GCS, {10'h000, en, 2'b00, 6'h3f, 8'h00});
      rd(dec_pkg::OFF_COUNT, 32'h00ffffff, {8'h00, resumeCnt});
      rd(dec_pkg::OFF_PCIADDR, 32'hffffffff, pa + {8'h00, cnt - resumeCnt});
      rd(dec_pkg::OFF_VMEADDR, 32'hffffffff, va + {8'h00, cnt - resumeCnt});
      rd(dec_pkg::OFF_GCS, 32'h003fff80, {10'h000, en, 16'h0000});
    end
  endtask
  always #5 mclk = ~mclk;
  always @(posedge mclk) rnd <= xs(rnd);
  initial
  begin
    int r;
    int k;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    #1;
    chk({27'h0, dmaActive, srcReadEn, dstWriteEn, pciIrqOut, vmeIrqOut}, 32'h0);
    rd(dec_pkg::OFF_GCS, 32'hffffffff, 32'h0);
    wr(8'h40, 32'hffffffff);
    rd(8'h40, 32'hffffffff, 32'h0);
    for (r = 0; r < 3; r++)
      for (k = 0; k < 6; k++)
        run(k, (r == 0) ? 6'h3f : (r == 1) ? ~(6'h01 << k) : rnd[5:0], (r == 0) ? 2'b11 : rnd[9:8],
          (r == 2) ? rnd[12] : r[0]);
    close_out();
  end
endmodule // test_dma_error_termination_control
